//--- hdl/pstr_sequencer.sv
// Purpose: program sequencing, return stack, vectors and table reads
// Assumes: program ROM answers combinationally on rom_addr
// Notes:   decoder drives ctl_* for the word in instr during exec_valid
`timescale 1ns/1ps
module pstr_sequencer #(
   parameter int unsigned STACK_LEVELS = pstr_pkg::STACK_DEPTH
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // program rom
   output logic      [11:0] rom_addr,
   input  wire logic [14:0] rom_data,
   // decoder side
   output logic      [14:0] instr,
   output logic             exec_valid,
   output logic      [1:0]  phase,
   input  wire logic [2:0]  ctl_op,
   input  wire logic        ctl_skip_true,
   input  wire logic [11:0] ctl_target,
   input  wire logic [7:0]  ctl_dmem_addr,
   // data memory write port for table reads
   output logic             dmem_we,
   output logic      [7:0]  dmem_addr,
   output logic      [7:0]  dmem_wdata,
   // interrupts, already gated by their own enables
   input  wire logic [5:0]  irq_req,
   output logic      [5:0]  irq_ack,
   input  wire logic        wake
);
   localparam int unsigned SP_W = $clog2(STACK_LEVELS + 1);

   // pointer field in the status register holds four bits at most
   if (STACK_LEVELS < 1 || STACK_LEVELS > 15) begin : g_bad_levels
      $error("pstr_sequencer: STACK_LEVELS out of range");
   end

   pstr_pkg::pstr_state_e state_reg;
   logic [1:0]   phase_reg;
   logic [11:0]  program_counter_reg;
   logic [11:0]  pc_next;
   logic [14:0]  instr_reg;
   logic         instr_valid_reg;
   logic [7:0]   table_pointer_reg;
   logic [6:0]   table_high_reg;
   logic         global_irq_enable_reg;
   logic         pcl_pend_reg;
   logic [7:0]   pcl_val_reg;
   logic [11:0]  tbl_addr_reg;
   logic [7:0]   tbl_dest_reg;
   logic [10:0]  sst_cnt_reg;
   logic [11:0]  stack_mem [STACK_LEVELS];
   logic [SP_W-1:0] return_stack_pointer_reg;
   logic [SP_W-1:0] wr_idx;
   logic [SP_W-1:0] top_idx;
   logic         stack_full;
   logic         cycle_end;
   logic         running;
   logic         do_irq;
   logic [2:0]   irq_sel;
   logic         push;
   logic         pop;
   logic         flush;
   logic [11:0]  push_val;
   logic         bus_ack_reg;
   logic         bus_req;
   logic         bus_wr;
   logic [5:0]   bus_idx;

   // lowest numbered request has the lowest vector
   function automatic logic [2:0] pick_irq(input logic [5:0] req);
      logic [2:0] sel;
      sel = 3'd0;
      for (int i = pstr_pkg::IRQ_N - 1; i >= 0; i--) begin
         if (req[i]) begin
            sel = 3'(i);
         end
      end
      return sel;
   endfunction

   // vector address of request number n
   function automatic logic [11:0] vec_of(input logic [2:0] n);
      return 12'(({9'h000, n} + 12'h001) * pstr_pkg::VEC_STEP);
   endfunction

   // four phase divider
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         phase_reg <= 2'h0;
      end else begin
         phase_reg <= phase_reg + 2'h1;
      end
   end

   assign phase      = phase_reg;
   assign cycle_end  = (phase_reg == 2'h3);
   assign running    = (state_reg == pstr_pkg::PSTR_RUN);
   assign exec_valid = running && instr_valid_reg;
   assign instr      = instr_reg;
   assign stack_full = (return_stack_pointer_reg == SP_W'(STACK_LEVELS));

   // rom port: table word in table cycle, else the next instruction
   always_comb begin
      rom_addr = program_counter_reg;
      if (state_reg == pstr_pkg::PSTR_TABLE) begin
         rom_addr = tbl_addr_reg;
      end
   end

   // interrupt taken only beside a plain instruction or a dummy cycle;
   // a transfer, skip, table read or halt in execution would be lost
   assign irq_sel = pick_irq(irq_req);
   assign do_irq  = cycle_end && running && global_irq_enable_reg
                    && (|irq_req) && !stack_full
                    && !(instr_valid_reg
                         && pstr_pkg::pstr_op_e'(ctl_op)
                            != pstr_pkg::PSTR_OP_NEXT)
                    && !pcl_pend_reg;

   // next program counter and dummy-cycle decision
   always_comb begin
      pc_next  = program_counter_reg + 12'h001;
      flush    = 1'b0;
      push     = 1'b0;
      pop      = 1'b0;
      push_val = program_counter_reg;
      if (pcl_pend_reg) begin
         pc_next = {program_counter_reg[11:8], pcl_val_reg};
         flush   = 1'b1;
      end else if (do_irq) begin
         // the word just fetched is discarded and re-fetched on return
         pc_next = vec_of(irq_sel);
         push    = 1'b1;
         flush   = 1'b1;
      end else if (exec_valid) begin
         case (pstr_pkg::pstr_op_e'(ctl_op))
            pstr_pkg::PSTR_OP_SKIP: begin
               flush = ctl_skip_true;
            end
            pstr_pkg::PSTR_OP_JUMP: begin
               pc_next = ctl_target;
               flush   = 1'b1;
            end
            pstr_pkg::PSTR_OP_CALL: begin
               pc_next = ctl_target;
               push    = 1'b1;
               flush   = 1'b1;
            end
            pstr_pkg::PSTR_OP_RET: begin
               pc_next = stack_mem[top_idx];
               pop     = (return_stack_pointer_reg != '0);
               flush   = 1'b1;
            end
            default: begin
               flush = 1'b0;
            end
         endcase
      end
   end

   // sequencing state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= pstr_pkg::PSTR_RUN;
      end else if (cycle_end) begin
         case (state_reg)
            pstr_pkg::PSTR_RUN: begin
               if (exec_valid && !pcl_pend_reg && !do_irq) begin
                  case (pstr_pkg::pstr_op_e'(ctl_op))
                     pstr_pkg::PSTR_OP_TBLC,
                     pstr_pkg::PSTR_OP_TBLL:
                        state_reg <= pstr_pkg::PSTR_TABLE;
                     pstr_pkg::PSTR_OP_HALT:
                        state_reg <= pstr_pkg::PSTR_HALT;
                     default:
                        state_reg <= pstr_pkg::PSTR_RUN;
                  endcase
               end
            end
            pstr_pkg::PSTR_TABLE: state_reg <= pstr_pkg::PSTR_RUN;
            pstr_pkg::PSTR_HALT: begin
               if (wake || (|irq_req)) begin
                  state_reg <= pstr_pkg::PSTR_WAKE;
               end
            end
            pstr_pkg::PSTR_WAKE: begin
               if (sst_cnt_reg == 11'(pstr_pkg::SST_CYCLES)) begin
                  state_reg <= pstr_pkg::PSTR_RUN;
               end
            end
            default: state_reg <= pstr_pkg::PSTR_RUN;
         endcase
      end
   end

   // start-up count of system clocks after wake
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sst_cnt_reg <= 11'h000;
      end else if (state_reg != pstr_pkg::PSTR_WAKE) begin
         sst_cnt_reg <= 11'h001;
      end else if (sst_cnt_reg != 11'(pstr_pkg::SST_CYCLES)) begin
         sst_cnt_reg <= sst_cnt_reg + 11'h001;
      end
   end

   // program counter and fetch register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         program_counter_reg <= pstr_pkg::RESET_VEC;
         instr_reg           <= 15'h0000;
         instr_valid_reg     <= 1'b0;
      end else if (cycle_end && running) begin
         program_counter_reg <= pc_next;
         instr_reg           <= rom_data;
         instr_valid_reg     <= !flush;
      end else if (cycle_end && pcl_pend_reg) begin
         program_counter_reg <= pc_next;
         instr_valid_reg     <= 1'b0;
      end
   end

   // table read: address latch, then word split
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tbl_addr_reg   <= 12'h000;
         tbl_dest_reg   <= 8'h00;
         table_high_reg <= 7'h00;
      end else if (cycle_end && running && exec_valid) begin
         tbl_dest_reg <= ctl_dmem_addr;
         if (pstr_pkg::pstr_op_e'(ctl_op) == pstr_pkg::PSTR_OP_TBLL) begin
            tbl_addr_reg <= {pstr_pkg::LAST_PAGE,
                             table_pointer_reg};
         end else begin
            tbl_addr_reg <= {program_counter_reg[11:8],
                             table_pointer_reg};
         end
      end else if (cycle_end
                   && state_reg == pstr_pkg::PSTR_TABLE) begin
         table_high_reg <= rom_data[14:8];
      end
   end

   // data memory write at the end of the table cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dmem_we    <= 1'b0;
         dmem_addr  <= 8'h00;
         dmem_wdata <= 8'h00;
      end else begin
         dmem_we <= cycle_end && state_reg == pstr_pkg::PSTR_TABLE;
         if (cycle_end && state_reg == pstr_pkg::PSTR_TABLE) begin
            dmem_addr  <= tbl_dest_reg;
            dmem_wdata <= rom_data[7:0];
         end
      end
   end

   // return stack, shifted down when full so an overflowing call drops the oldest
   assign wr_idx  = (return_stack_pointer_reg == SP_W'(STACK_LEVELS))
                    ? '0 : return_stack_pointer_reg;
   assign top_idx = (return_stack_pointer_reg == '0)
                    ? '0 : return_stack_pointer_reg - SP_W'(1);
   assign bus_req = (avs_read || avs_write) && !bus_ack_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         return_stack_pointer_reg <= '0;
         for (int i = 0; i < STACK_LEVELS; i++) begin
            stack_mem[i] <= 12'h000;
         end
      end else if (cycle_end && running && push) begin
         if (stack_full) begin
            for (int i = 0; i < STACK_LEVELS - 1; i++) begin
               stack_mem[i] <= stack_mem[i+1];
            end
            stack_mem[STACK_LEVELS-1] <= push_val;
         end else begin
            stack_mem[wr_idx] <= push_val;
            return_stack_pointer_reg <= return_stack_pointer_reg
                                        + SP_W'(1);
         end
      end else if (cycle_end && running && pop) begin
         return_stack_pointer_reg <= return_stack_pointer_reg
                                     - SP_W'(1);
      end
   end

   // interrupt acknowledge pulse, one per taken request
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_ack <= 6'h00;
      end else begin
         irq_ack <= do_irq ? 6'(6'h01 << irq_sel) : 6'h00;
      end
   end

   // bus decode; a request waits one cycle, then completes
   assign bus_idx         = avs_address[7:2];
   assign bus_wr          = avs_write && bus_ack_reg && avs_byteenable[0];
   assign avs_waitrequest = bus_req;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bus_ack_reg <= 1'b0;
      end else begin
         bus_ack_reg <= bus_req;
      end
   end

   // software registers; hardware clear of enable wins over writes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         table_pointer_reg     <= pstr_pkg::TBL_PTR_RST;
         global_irq_enable_reg <= pstr_pkg::GIE_RST;
      end else begin
         if (bus_wr && bus_idx == pstr_pkg::IDX_TBL_PTR) begin
            table_pointer_reg <= avs_writedata[7:0];
         end
         if (do_irq) begin
            global_irq_enable_reg <= 1'b0;
         end else if (bus_wr && bus_idx == pstr_pkg::IDX_SEQ_CTL) begin
            global_irq_enable_reg <=
               avs_writedata[pstr_pkg::CTL_GIE_BIT];
         end
      end
   end

   // short jump request held until the instruction cycle boundary
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pcl_pend_reg <= 1'b0;
         pcl_val_reg  <= 8'h00;
      end else if (bus_wr && bus_idx == pstr_pkg::IDX_PC_LOW) begin
         pcl_pend_reg <= 1'b1;
         pcl_val_reg  <= avs_writedata[7:0];
      end else if (cycle_end) begin
         pcl_pend_reg <= 1'b0;
      end
   end

   // read data; high byte register ignores writes
   always_comb begin
      avs_readdata = 32'h0000_0000;
      case (bus_idx)
         pstr_pkg::IDX_PC_LOW:
            avs_readdata[7:0] = program_counter_reg[7:0];
         pstr_pkg::IDX_TBL_PTR:
            avs_readdata[7:0] = table_pointer_reg;
         pstr_pkg::IDX_TBL_HI:
            avs_readdata[7:0] = {1'b0, table_high_reg};
         pstr_pkg::IDX_SEQ_CTL: begin
            avs_readdata[pstr_pkg::CTL_GIE_BIT]  = global_irq_enable_reg;
            avs_readdata[pstr_pkg::CTL_HALT_BIT] = !running;
            avs_readdata[pstr_pkg::CTL_FULL_BIT] = stack_full;
            avs_readdata[pstr_pkg::CTL_SP_LSB +: 4] =
               4'(return_stack_pointer_reg);
         end
         default: avs_readdata = 32'h0000_0000;
      endcase
   end
endmodule

//--- hdl/pstr_pkg.sv
// Purpose: shared constants for the program sequencer and table read unit
// Assumes: 200 MHz system clock, Avalon-MM register access
// Notes:   register index times four gives the byte address
package pstr_pkg;
   localparam int unsigned PC_W       = 12;
   localparam int unsigned ROM_W      = 15;
   localparam int unsigned STACK_DEPTH = 6;
   localparam int unsigned PHASES     = 4;
   // register indices, byte address = 4 * index
   localparam logic [5:0] IDX_PC_LOW  = 6'h06;
   localparam logic [5:0] IDX_TBL_PTR = 6'h07;
   localparam logic [5:0] IDX_TBL_HI  = 6'h08;
   localparam logic [5:0] IDX_SEQ_CTL = 6'h0C;
   // control register fields
   localparam int unsigned CTL_GIE_BIT  = 0;
   localparam int unsigned CTL_HALT_BIT = 1;
   localparam int unsigned CTL_FULL_BIT = 2;
   localparam int unsigned CTL_SP_LSB   = 4;
   localparam logic        GIE_RST      = 1'b0;
   localparam logic [7:0]  TBL_PTR_RST  = 8'h00;
   // fixed program addresses
   localparam logic [11:0] RESET_VEC  = 12'h000;
   localparam logic [11:0] VEC_STEP   = 12'h004;
   localparam int unsigned IRQ_N      = 6;
   localparam logic [3:0]  LAST_PAGE  = 4'hF;
   // start-up after wake, in system clock periods
   localparam int unsigned SST_PERIODS = 1024;
   localparam real         CLK_MHZ     = 200.0;
   localparam int unsigned SST_CYCLES  = SST_PERIODS;
   // sequencing operations presented by the instruction decoder
   typedef enum logic [2:0] {
      PSTR_OP_NEXT  = 3'b000,
      PSTR_OP_SKIP  = 3'b001,
      PSTR_OP_JUMP  = 3'b010,
      PSTR_OP_CALL  = 3'b011,
      PSTR_OP_RET   = 3'b100,
      PSTR_OP_TBLC  = 3'b101,
      PSTR_OP_TBLL  = 3'b110,
      PSTR_OP_HALT  = 3'b111
   } pstr_op_e;
   typedef enum logic [1:0] {
      PSTR_RUN   = 2'b00,
      PSTR_TABLE = 2'b01,
      PSTR_HALT  = 2'b10,
      PSTR_WAKE  = 2'b11
   } pstr_state_e;
endpackage

//--- verification/pstr_rom_model.sv
// Purpose: program memory stand-in that answers at once from its address
// Assumes: word content is a fixed scramble of the address
// Notes:   addresses that differ in any bit give different words, never an unknown
`timescale 1ns/1ps
module pstr_rom_model (
   input  wire logic [11:0] rom_addr,
   output logic      [14:0] rom_data
);
   // low byte and upper bits differ, so swapped table halves show up
   assign rom_data = {rom_addr[6:0], rom_addr[11:4]} ^ 15'h2D3C;
endmodule

//--- verification/pstr_sequencer_monitor.sv
// Purpose: concurrent checks on the program sequencer ports
// Assumes: one clock domain, resetn asynchronous and active low
// Notes:   quiet counter keeps fetch checks clear of pending pc writes
`timescale 1ns/1ps
module pstr_sequencer_monitor #(
   parameter int unsigned STACK_LEVELS = pstr_pkg::STACK_DEPTH
) (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic [11:0] rom_addr,
   input wire logic [14:0] rom_data,
   input wire logic [14:0] instr,
   input wire logic        exec_valid,
   input wire logic [1:0]  phase,
   input wire logic [2:0]  ctl_op,
   input wire logic        ctl_skip_true,
   input wire logic [11:0] ctl_target,
   input wire logic        dmem_we,
   input wire logic [5:0]  irq_req,
   input wire logic [5:0]  irq_ack
);
   logic [3:0]  quiet;
   logic [11:0] ack_vec;
   logic        go;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // cycles since the last bus write, saturating
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         quiet <= 4'h0;
      end else if (avs_write) begin
         quiet <= 4'h0;
      end else if (quiet != 4'hF) begin
         quiet <= quiet + 4'h1;
      end
   end
   // vector expected for whichever acknowledge bit is up
   always_comb begin
      ack_vec = 12'h000;
      for (int i = 0; i < 6; i++) begin
         if (irq_ack[i]) ack_vec = 12'((i + 1) * 4);
      end
   end
   // clean execute edge: no interrupt or pending pc write can steal it
   assign go = phase == 2'h3 && exec_valid && irq_req == 6'h00 &&
               quiet > 4'h8;
   chk_phase_step: assert property (
      $past(resetn) |-> phase == $past(phase) + 2'h1)
      else $error("phase did not advance by one");
   chk_instr_hold: assert property (
      $past(resetn) && phase != 2'h0 |-> $stable(instr) && $stable(exec_valid))
      else $error("instruction changed inside a cycle");
   chk_fetch_next: assert property (
      go && ctl_op == pstr_pkg::PSTR_OP_NEXT |=> exec_valid &&
      instr == $past(rom_data) && rom_addr == $past(rom_addr) + 12'h001)
      else $error("sequential fetch wrong");
   chk_jump_dummy: assert property (
      go && ctl_op inside {pstr_pkg::PSTR_OP_JUMP, pstr_pkg::PSTR_OP_CALL}
      |=> !exec_valid && rom_addr == $past(ctl_target))
      else $error("jump target or dummy cycle wrong");
   chk_skip_dummy: assert property (
      go && ctl_op == pstr_pkg::PSTR_OP_SKIP && ctl_skip_true
      |=> !exec_valid ##4 exec_valid)
      else $error("true skip did not give one dummy cycle");
   chk_table_two: assert property (
      go && ctl_op inside {pstr_pkg::PSTR_OP_TBLC, pstr_pkg::PSTR_OP_TBLL}
      |=> !exec_valid ##4 exec_valid)
      else $error("table read not two cycles");
   chk_we_pulse: assert property (
      dmem_we |-> phase <= 2'h1 ##1 !dmem_we)
      else $error("table write strobe misplaced");
   chk_ack_vector: assert property (
      irq_ack != 6'h00 |-> $onehot(irq_ack) && rom_addr == ack_vec &&
      !exec_valid)
      else $error("interrupt vector wrong");
   chk_ack_lowest: assert property (
      irq_ack != 6'h00 |-> ((irq_ack - 6'h01) & $past(irq_req)) == 6'h00)
      else $error("lower interrupt request passed over");
   chk_bus_wait: assert property (
      $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus wait cycle wrong");
   cov_jump: cover property (go && ctl_op == pstr_pkg::PSTR_OP_JUMP);
   cov_table: cover property (dmem_we);
   cov_irq: cover property (irq_ack != 6'h00);
endmodule
bind pstr_sequencer pstr_sequencer_monitor #(
   .STACK_LEVELS(STACK_LEVELS)
) pstr_sequencer_monitor_inst (
   .clk(clk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .rom_addr(rom_addr),
   .rom_data(rom_data), .instr(instr), .exec_valid(exec_valid),
   .phase(phase), .ctl_op(ctl_op), .ctl_skip_true(ctl_skip_true),
   .ctl_target(ctl_target), .dmem_we(dmem_we), .irq_req(irq_req),
   .irq_ack(irq_ack)
);

//--- verification/tb_program_sequencer_table_read.sv
// Purpose: directed bench for the program sequencer and table reads
// Assumes: bench plays the instruction decoder and the bus master
// Notes:   expected words come from the bench's own copy of the scramble
`timescale 1ns/1ps
module tb_program_sequencer_table_read;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [11:0] rom_addr;
   logic [14:0] rom_data;
   logic [14:0] instr;
   logic        exec_valid;
   logic [1:0]  phase;
   logic [2:0]  ctl_op = 3'h0;
   logic        ctl_skip_true = 1'b0;
   logic [11:0] ctl_target = 12'h000;
   logic [7:0]  ctl_dmem_addr = 8'h00;
   logic        dmem_we;
   logic [7:0]  dmem_addr;
   logic [7:0]  dmem_wdata;
   logic [5:0]  irq_req = 6'h00;
   logic [5:0]  irq_ack;
   logic        wake = 1'b0;
   logic [3:0]  page;
   int          errors = 0;
   int          checks = 0;
   int          cyc = 0;
   int          ack_cnt = 0;
   // 200 MHz system clock, cycle and acknowledge counters
   always #2.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   always @(posedge clk) if (irq_ack !== 6'h00) ack_cnt <= ack_cnt + 1;
   pstr_sequencer pstr_sequencer_inst (
      .clk(clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rom_addr(rom_addr), .rom_data(rom_data), .instr(instr),
      .exec_valid(exec_valid), .phase(phase), .ctl_op(ctl_op),
      .ctl_skip_true(ctl_skip_true), .ctl_target(ctl_target),
      .ctl_dmem_addr(ctl_dmem_addr), .dmem_we(dmem_we),
      .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .irq_req(irq_req),
      .irq_ack(irq_ack), .wake(wake));
   pstr_rom_model pstr_rom_model_inst (
      .rom_addr(rom_addr), .rom_data(rom_data));
   function automatic logic [14:0] rom_word(input logic [11:0] a);
      return {a[6:0], a[11:4]} ^ 15'h2D3C;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // one bus transfer; held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [7:0] adr,
                      input logic [7:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= adr;
      avs_writedata <= {24'h000000, wd};
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 32) begin
         @(posedge clk);
         n++;
      end
      if (n == 32) errors++; // a stuck slave counts as a mismatch
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic at_p2;
      @(negedge clk);
      for (int n = 0; n < 8 && phase !== 2'h2; n++) @(negedge clk);
   endtask
   // present a decoder operation for the next executing instruction
   task automatic run_op(input logic [2:0] op, input logic [11:0] tgt,
                         input logic sk);
      @(negedge clk);
      for (int n = 0; n < 64 && !(phase === 2'h2 && exec_valid === 1'b1);
           n++) @(negedge clk);
      page = rom_addr[11:8];
      @(posedge clk);
      ctl_op <= op;
      ctl_target <= tgt;
      ctl_skip_true <= sk;
      @(posedge clk);
      ctl_op <= 3'h0;
      ctl_skip_true <= 1'b0;
   endtask
   task automatic wait_ack;
      @(negedge clk);
      for (int n = 0; n < 40 && irq_ack === 6'h00; n++) @(negedge clk);
   endtask
   task automatic t_reset;
      at_p2;
      check(rom_addr, 12'h000);
      check(exec_valid, 1'b0);
      at_p2;
      check(instr, rom_word(12'h000));
      check(rom_addr, 12'h001);
      $display("test reset done");
   endtask
   task automatic t_flow;
      run_op(pstr_pkg::PSTR_OP_JUMP, 12'h3F0, 1'b0);
      at_p2;
      check(exec_valid, 1'b0);
      check(rom_addr, 12'h3F0);
      at_p2;
      check(instr, rom_word(12'h3F0));
      run_op(pstr_pkg::PSTR_OP_SKIP, 12'h000, 1'b0);
      at_p2;
      check(rom_addr, 12'h3F3);
      run_op(pstr_pkg::PSTR_OP_SKIP, 12'h000, 1'b1);
      at_p2;
      check(exec_valid, 1'b0);
      at_p2;
      check(instr, rom_word(12'h3F5));
      run_op(pstr_pkg::PSTR_OP_CALL, 12'h500, 1'b0);
      at_p2;
      check(rom_addr, 12'h500);
      run_op(pstr_pkg::PSTR_OP_RET, 12'h000, 1'b0);
      at_p2;
      check(rom_addr, 12'h3F7);
      $display("test flow done");
   endtask
   task automatic t_pcl;
      logic [31:0] rd;
      bus(1'b1, 8'h18, 8'hA5, rd);
      at_p2;
      if (exec_valid === 1'b1) at_p2;
      check(exec_valid, 1'b0);
      check(rom_addr, 12'h3A5);
      $display("test short jump done");
   endtask
   // current page then last page, pointer loaded first
   task automatic t_table;
      logic [31:0] rd;
      logic [14:0] w;
      bus(1'b1, 8'h1C, 8'h5C, rd);
      bus(1'b0, 8'h1C, 8'h00, rd);
      check(rd, 32'h0000005C);
      // a write without its low byte lane must leave the pointer alone
      avs_byteenable <= 4'hE;
      bus(1'b1, 8'h1C, 8'hC3, rd);
      avs_byteenable <= 4'hF;
      bus(1'b0, 8'h1C, 8'h00, rd);
      check(rd, 32'h0000005C);
      bus(1'b1, 8'h20, 8'h33, rd);
      bus(1'b0, 8'h20, 8'h00, rd);
      check(rd, 32'h00000000);
      bus(1'b0, 8'h3C, 8'h00, rd);
      check(rd, 32'h00000000);
      for (int k = 0; k < 2; k++) begin
         ctl_dmem_addr <= 8'h70 + 8'(k);
         run_op(k ? pstr_pkg::PSTR_OP_TBLL : pstr_pkg::PSTR_OP_TBLC,
                12'h000, 1'b0);
         w = rom_word({k ? 4'hF : page, 8'h5C});
         at_p2;
         check(exec_valid, 1'b0);
         @(negedge clk);
         for (int n = 0; n < 8 && dmem_we !== 1'b1; n++) @(negedge clk);
         check(dmem_addr, 8'h70 + 8'(k));
         check(dmem_wdata, w[7:0]);
         at_p2;
         check(exec_valid, 1'b1);
         bus(1'b0, 8'h20, 8'h00, rd);
         check(rd, {25'h0000000, w[14:8]});
      end
      $display("test table done");
   endtask
   // six nested services fill the stack; a seventh must wait for a return
   task automatic t_irq;
      logic [31:0] rd;
      int          c0;
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, 8'h30, 8'h01, rd);
         irq_req <= 6'h3F << i;
         wait_ack;
         check(irq_ack, 6'h01 << i);
         check(rom_addr, 12'((i + 1) * 4));
         @(posedge clk);
         irq_req <= 6'h00;
         bus(1'b0, 8'h30, 8'h00, rd);
         check(rd[0], 1'b0);
      end
      check(rd[2], 1'b1);
      bus(1'b1, 8'h30, 8'h01, rd);
      irq_req <= 6'h01;
      c0 = ack_cnt;
      repeat (24) @(negedge clk);
      check(ack_cnt, c0);
      run_op(pstr_pkg::PSTR_OP_RET, 12'h000, 1'b0);
      wait_ack;
      check(irq_ack, 6'h01);
      @(posedge clk);
      irq_req <= 6'h00;
      $display("test interrupt done");
   endtask
   task automatic t_halt;
      logic [31:0] rd;
      int          t0;
      run_op(pstr_pkg::PSTR_OP_HALT, 12'h000, 1'b0);
      repeat (8) @(posedge clk);
      wake <= 1'b1;
      t0 = cyc;
      bus(1'b0, 8'h30, 8'h00, rd);
      check(rd[1], 1'b1);
      for (int n = 0; n < 1200 && exec_valid !== 1'b1; n++) @(negedge clk);
      check((cyc - t0) >= 1024 && (cyc - t0) <= 1040, 1'b1);
      @(posedge clk);
      wake <= 1'b0;
      $display("test halt done");
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      t_flow;
      t_pcl;
      t_table;
      t_irq;
      t_halt;
      print_verdict;
   end
   // the run needs about 1400 cycles; the limit of 20000 cycles gives it over ten times that
   initial begin
      #100000;
      errors++;
      print_verdict;
   end
endmodule
